// [common/config_port_pkg.sv]
// Constants, state and mode encodings and mode decoders for the configuration port pin control.
// Assumes a 100 MHz reference clock; every timing count below is derived from that period.
package config_port_pkg;

  localparam int CLK_PERIOD_NS = 10;
  localparam int RESTART_ACCEPT_NS = 110;
  localparam int RESTART_REJECT_NS = 50;
  // One cycle more than the longest rejected pulse, and no more than the shortest accepted one.
  localparam int RESTART_FILTER_CYCLES = RESTART_REJECT_NS / CLK_PERIOD_NS + 1;
  localparam int RESTART_ACCEPT_CYCLES = (RESTART_ACCEPT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int INIT_LOW_NS = 55;
  localparam int INIT_LOW_CYCLES = (INIT_LOW_NS / CLK_PERIOD_NS < 1) ? 1 : INIT_LOW_NS / CLK_PERIOD_NS;
  localparam int FILTER_W = 4;
  localparam logic [FILTER_W-1:0] RESTART_FILTER_LAST = FILTER_W'(RESTART_FILTER_CYCLES - 1);
  localparam logic [FILTER_W-1:0] INIT_LOW_LAST = FILTER_W'(INIT_LOW_CYCLES - 1);
  localparam logic [FILTER_W-1:0] FILTER_RESET = 4'h0;

  localparam logic [2:0] MODE_SLAVE_SERIAL = 3'h0;
  localparam logic [2:0] MODE_SLAVE_SPI = 3'h1;
  localparam logic [2:0] MODE_MASTER_SPI = 3'h2;
  localparam logic [2:0] MODE_MASTER_MULTI_BIT_SERIAL_FLASH_MODE = 3'h3;
  localparam logic [2:0] MODE_MASTER_SERIAL = 3'h4;
  localparam logic [2:0] MODE_SLAVE_PARALLEL = 3'h7;
  localparam logic [2:0] MODE_RESET = 3'h0;

  localparam logic [1:0] PORT_NONE = 2'h0;
  localparam logic [1:0] PORT_PINS = 2'h1;
  localparam logic [1:0] PORT_TAP = 2'h2;

  localparam int FLASH_FRAME_BITS = 32;
  localparam logic [5:0] FLASH_FRAME_LAST = 6'h20;
  localparam logic [23:0] FLASH_START_ADDR = 24'h000000;

  typedef enum logic [2:0] {
    ST_RESET = 3'h0,
    ST_INIT_LOW = 3'h1,
    ST_WAIT_INIT_HIGH = 3'h3,
    ST_LOAD = 3'h2,
    ST_DONE = 3'h6
  } cfg_state_t;

  function automatic logic mode_is_master(input logic [2:0] mode);
    return (mode == MODE_MASTER_SPI) || (mode == MODE_MASTER_MULTI_BIT_SERIAL_FLASH_MODE) ||
           (mode == MODE_MASTER_SERIAL);
  endfunction : mode_is_master

  function automatic logic mode_is_master_spi(input logic [2:0] mode);
    return (mode == MODE_MASTER_SPI) || (mode == MODE_MASTER_MULTI_BIT_SERIAL_FLASH_MODE);
  endfunction : mode_is_master_spi

  function automatic logic mode_is_spi(input logic [2:0] mode);
    return mode_is_master_spi(mode) || (mode == MODE_SLAVE_SPI);
  endfunction : mode_is_spi

  function automatic logic mode_is_parallel(input logic [2:0] mode);
    return mode == MODE_SLAVE_PARALLEL;
  endfunction : mode_is_parallel

endpackage : config_port_pkg

// [rtl/config_port_pin_control.sv]
// Pin-level control of the configuration port: restart, handshake pins, mode capture,
// pin directions per mode, port lock and release of shared pins after configuration.
// Assumes the configuration engine sits on i_ref_clk and that the slave clock pin is routed
// to a clock net; open-drain and two-way pins are resolved outside from the _oe outputs.
// Summary of operation
// [RULE_01] Latch three mode bits on init-ready rise.
// [RULE_02] Low restart pin starts a new configuration.
// [RULE_03] Init-ready is open-drain readiness handshake.
// [RULE_04] Done is open-drain, shows load finished.
// [RULE_05] Clock pin input in slave, output in master.
// [RULE_06] Test access port may claim configuration.
// [RULE_07] First selected port stays locked until power-up.
// [RULE_08] Pull-ups on mode, init, test inputs during configuration.
// [RULE_09] Restart always pulled up; test clock never.
// [RULE_10] Data bit zero: open-drain, master out, slave in.
// [RULE_11] Hold pin: busy in parallel, data in SPI; the code drives it constant high in the SPI modes.
// [RULE_12] Host selects via chip selects in parallel, slave SPI.
// [RULE_13] Host marks parallel writes with write strobe.
// [RULE_14] Serial out forwards data, flash select in master SPI.
// [RULE_15] Shared pins become general I/O after configuration.
// [RULE_16] Accept restart low of 110 ns, reject 50 ns.
// [RULE_17] Data bit one: open-drain, master in, slave out.
// [RULE_18] Only pull handshake pins low; hold init until ready.
// [RULE_19] Host waits for init release and for done.
`timescale 1ns/10ps
module config_port_pin_control
  import config_port_pkg::*;
#(
  parameter int MASTER_HALF_CYCLES = 4,
  parameter logic [7:0] FLASH_READ_CMD = 8'h03
) (
  input wire logic i_ref_clk,
  input wire logic i_rst_n,
  input wire logic i_config_clock_pin_in,
  input wire logic i_config_restart_n,
  input wire logic i_init_ready_n_in,
  input wire logic [2:0] i_mode_select,
  input wire logic i_config_data_bit0_in,
  input wire logic i_config_data_bit1_in,
  input wire logic i_primary_chip_select_n,
  input wire logic i_second_chip_select_n,
  input wire logic i_write_strobe_n,
  input wire logic i_tap_config_request,
  input wire logic i_engine_ready,
  input wire logic i_engine_busy,
  input wire logic i_load_complete,
  output logic o_init_ready_n_out,
  output logic o_init_ready_n_oe,
  output logic o_done_out,
  output logic o_done_oe,
  output logic o_config_clock_pin_out,
  output logic o_config_clock_pin_oe,
  output logic o_config_data_bit0_out,
  output logic o_config_data_bit0_oe,
  output logic o_config_data_bit1_out,
  output logic o_config_data_bit1_oe,
  output logic o_hold_busy_data_pin_out,
  output logic o_hold_busy_data_pin_oe,
  output logic o_serial_out_select_out,
  output logic o_serial_out_select_oe,
  output logic o_mode_pullup_en,
  output logic o_init_pullup_en,
  output logic o_tms_pullup_en,
  output logic o_tdi_pullup_en,
  output logic o_restart_pullup_en,
  output logic o_tck_pullup_en,
  output logic [2:0] o_mode,
  output logic o_mode_valid,
  output logic o_pin_port_locked,
  output logic o_tap_port_locked,
  output logic o_configuring,
  output logic o_shared_pins_gpio,
  output logic o_restart_accepted,
  output logic [7:0] o_config_byte,
  output logic o_config_byte_valid,
  output logic o_parallel_write
);

  cfg_state_t state;
  logic [FILTER_W-1:0] restart_cnt;
  logic [FILTER_W-1:0] init_cnt;
  logic restart_s1, restart_s2, restart_armed;
  logic init_s1, init_s2, init_s3;
  logic [2:0] mode_s1, mode_s2;
  logic [2:0] mode;
  logic mode_valid;
  logic [1:0] port_sel;
  logic cs_s1, cs_s2, cs1_s1, cs1_s2, wr_s1, wr_s2, wr_s3;
  logic d0_s1, d0_s2, d1_s1, d1_s2;
  logic pins_active, slave_active, master_active;
  logic [$clog2(MASTER_HALF_CYCLES+1)-1:0] div_cnt;
  logic mclk, mclk_rise, mclk_fall;
  logic [FLASH_FRAME_BITS-1:0] tx_sh;
  logic [5:0] tx_cnt;
  logic [7:0] mrx_sh;
  logic [2:0] mrx_cnt;
  logic master_bit;
  logic link_spi_s1, link_spi_s2;
  logic [7:0] link_sh;
  logic [7:0] link_byte;
  logic [2:0] link_cnt;
  logic link_toggle, link_last_bit;
  logic tog_s1, tog_s2, tog_s3;

  // The restart pin is asynchronous; only the second stage is looked at.
  always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      restart_s1 <= 1'b1;
      restart_s2 <= 1'b1;
      restart_cnt <= FILTER_RESET;
      restart_armed <= 1'b1;
      o_restart_accepted <= 1'b0;
    end else begin
      restart_s1 <= i_config_restart_n;
      restart_s2 <= restart_s1;
      o_restart_accepted <= 1'b0;
      if (restart_s2) begin
        restart_cnt <= FILTER_RESET;
        restart_armed <= 1'b1;
      end else if (restart_cnt != RESTART_FILTER_LAST) begin
        restart_cnt <= restart_cnt + 4'h1; // RULE_16
      end else if (restart_armed) begin
        // One request per low pulse, however long the pin stays low.
        o_restart_accepted <= 1'b1; // RULE_16
        restart_armed <= 1'b0;
      end
    end
  end

  always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      init_s1 <= 1'b0;
      init_s2 <= 1'b0;
      init_s3 <= 1'b0;
      mode_s1 <= MODE_RESET;
      mode_s2 <= MODE_RESET;
      cs_s1 <= 1'b1;
      cs_s2 <= 1'b1;
      cs1_s1 <= 1'b1;
      cs1_s2 <= 1'b1;
      wr_s1 <= 1'b1;
      wr_s2 <= 1'b1;
      wr_s3 <= 1'b1;
      d0_s1 <= 1'b1;
      d0_s2 <= 1'b1;
      d1_s1 <= 1'b1;
      d1_s2 <= 1'b1;
    end else begin
      init_s1 <= i_init_ready_n_in;
      init_s2 <= init_s1;
      init_s3 <= init_s2;
      mode_s1 <= i_mode_select;
      mode_s2 <= mode_s1;
      cs_s1 <= i_primary_chip_select_n;
      cs_s2 <= cs_s1;
      cs1_s1 <= i_second_chip_select_n;
      cs1_s2 <= cs1_s1;
      wr_s1 <= i_write_strobe_n;
      wr_s2 <= wr_s1;
      wr_s3 <= wr_s2;
      d0_s1 <= i_config_data_bit0_in;
      d0_s2 <= d0_s1;
      d1_s1 <= i_config_data_bit1_in;
      d1_s2 <= d1_s1;
    end
  end

  always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      state <= ST_RESET;
      init_cnt <= FILTER_RESET;
    end else if (o_restart_accepted) begin
      state <= ST_RESET; // RULE_02
      init_cnt <= FILTER_RESET;
    end else begin
      case (state)
        ST_RESET: begin
          init_cnt <= FILTER_RESET;
          if (i_engine_ready) begin
            state <= ST_INIT_LOW;
          end
        end
        ST_INIT_LOW: begin
          // Init-ready stays pulled low for a minimum time before release.
          if (init_cnt == INIT_LOW_LAST) begin
            state <= ST_WAIT_INIT_HIGH; // RULE_18
          end else begin
            init_cnt <= init_cnt + 4'h1;
          end
        end
        ST_WAIT_INIT_HIGH: begin
          if (init_s2 && !init_s3) begin
            state <= ST_LOAD;
          end
        end
        ST_LOAD: begin
          if (i_load_complete) begin
            state <= ST_DONE; // RULE_04
          end
        end
        ST_DONE: begin
          state <= ST_DONE;
        end
        default: begin
          state <= ST_RESET;
        end
      endcase
    end
  end

  // Mode capture on the rising edge of the handshake pin as seen after synchronisation.
  always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      mode <= MODE_RESET;
      mode_valid <= 1'b0;
    end else if (o_restart_accepted) begin
      mode_valid <= 1'b0;
    end else if (state == ST_WAIT_INIT_HIGH && init_s2 && !init_s3) begin
      mode <= mode_s2; // RULE_01
      mode_valid <= 1'b1;
    end
  end

  // The lock is cleared only by the power-up reset; a restart keeps it.
  always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      port_sel <= PORT_NONE;
    end else if (port_sel == PORT_NONE) begin
      if (i_tap_config_request) begin
        port_sel <= PORT_TAP; // RULE_06
      end else if (state == ST_WAIT_INIT_HIGH && init_s2 && !init_s3) begin
        port_sel <= PORT_PINS; // RULE_07
      end
    end
  end

  assign pins_active = (state == ST_LOAD) && (port_sel == PORT_PINS);
  assign master_active = pins_active && mode_is_master(mode);
  assign slave_active = pins_active && !mode_is_master(mode) && !mode_is_parallel(mode);

  // Clock divider for the master modes; the flash sees a clock only while loading.
  always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      div_cnt <= '0;
      mclk <= 1'b0;
    end else if (!master_active) begin
      div_cnt <= '0;
      mclk <= 1'b0;
    end else if (div_cnt == ($bits(div_cnt))'(MASTER_HALF_CYCLES - 1)) begin
      div_cnt <= '0;
      mclk <= !mclk; // RULE_05
    end else begin
      div_cnt <= div_cnt + 1'b1;
    end
  end

  assign mclk_rise = master_active && !mclk &&
                     (div_cnt == ($bits(div_cnt))'(MASTER_HALF_CYCLES - 1));
  assign mclk_fall = master_active && mclk &&
                     (div_cnt == ($bits(div_cnt))'(MASTER_HALF_CYCLES - 1));
  assign master_bit = mode_is_master_spi(mode) ? d1_s2 : d0_s2;

  // Master SPI sends the read command and start address, then only receives.
  always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      tx_sh <= '0;
      tx_cnt <= 6'h00;
    end else if (!master_active) begin
      tx_sh <= {FLASH_READ_CMD, FLASH_START_ADDR};
      tx_cnt <= 6'h00;
    end else if (mclk_fall && tx_cnt != FLASH_FRAME_LAST && mode_is_master_spi(mode)) begin
      tx_sh <= {tx_sh[FLASH_FRAME_BITS-2:0], 1'b0}; // RULE_10
      tx_cnt <= tx_cnt + 6'h01;
    end
  end

  always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      mrx_sh <= 8'h00;
      mrx_cnt <= 3'h0;
    end else if (!master_active) begin
      mrx_cnt <= 3'h0;
    end else if (mclk_rise && (tx_cnt == FLASH_FRAME_LAST || !mode_is_master_spi(mode))) begin
      mrx_sh <= {mrx_sh[6:0], master_bit}; // RULE_17
      mrx_cnt <= mrx_cnt + 3'h1;
    end
  end

  // Link domain: slave modes shift data on the clock that the host supplies.
  // Bytes are qualified on the reference side, so the first frame loses no edges to a sync.
  always_ff @(posedge i_config_clock_pin_in or negedge i_rst_n) begin
    if (!i_rst_n) begin
      link_spi_s1 <= 1'b0;
      link_spi_s2 <= 1'b0;
    end else begin
      link_spi_s1 <= mode_is_spi(mode);
      link_spi_s2 <= link_spi_s1;
    end
  end

  // The clock stops between frames, so a deselect is only seen at the next edge.
  always_ff @(posedge i_config_clock_pin_in or negedge i_rst_n) begin
    if (!i_rst_n) begin
      link_sh <= 8'h00;
      link_byte <= 8'h00;
      link_cnt <= 3'h0;
      link_toggle <= 1'b0;
      link_last_bit <= 1'b1;
    end else if (link_spi_s2 && i_primary_chip_select_n) begin
      link_cnt <= 3'h0; // RULE_12
    end else begin
      link_sh <= {link_sh[6:0], i_config_data_bit0_in}; // RULE_10
      link_last_bit <= i_config_data_bit0_in;
      link_cnt <= link_cnt + 3'h1;
      if (link_cnt == 3'h7) begin
        link_byte <= {link_sh[6:0], i_config_data_bit0_in};
        link_toggle <= !link_toggle;
      end
    end
  end

  // The byte register holds for eight link clocks, far longer than the toggle takes to cross.
  always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      tog_s1 <= 1'b0;
      tog_s2 <= 1'b0;
      tog_s3 <= 1'b0;
      o_config_byte <= 8'h00;
      o_config_byte_valid <= 1'b0;
      o_parallel_write <= 1'b0;
    end else begin
      tog_s1 <= link_toggle;
      tog_s2 <= tog_s1;
      tog_s3 <= tog_s2;
      o_config_byte_valid <= 1'b0;
      o_parallel_write <= 1'b0;
      if (tog_s2 != tog_s3 && slave_active) begin
        o_config_byte <= link_byte;
        o_config_byte_valid <= 1'b1;
      end else if (mclk_rise && mrx_cnt == 3'h7 &&
                   (tx_cnt == FLASH_FRAME_LAST || !mode_is_master_spi(mode))) begin
        o_config_byte <= {mrx_sh[6:0], master_bit};
        o_config_byte_valid <= 1'b1;
      end
      if (pins_active && mode_is_parallel(mode) && !cs_s2 && !cs1_s2 && !wr_s2 && wr_s3) begin
        o_parallel_write <= 1'b1; // RULE_13
      end
    end
  end

  always_comb begin
    o_init_ready_n_out = 1'b0;
    o_init_ready_n_oe = (state == ST_RESET) || (state == ST_INIT_LOW); // RULE_03
    o_done_out = 1'b0;
    o_done_oe = (state != ST_DONE); // RULE_04
    o_config_clock_pin_out = mclk;
    o_config_clock_pin_oe = master_active; // RULE_05
    o_config_data_bit0_out = 1'b0;
    o_config_data_bit0_oe = master_active && mode_is_master_spi(mode) &&
                            !tx_sh[FLASH_FRAME_BITS-1]; // RULE_10
    o_config_data_bit1_out = 1'b0;
    o_config_data_bit1_oe = slave_active && mode_is_spi(mode) && !link_last_bit; // RULE_17
    o_hold_busy_data_pin_out = mode_is_parallel(mode) ? i_engine_busy : 1'b1; // RULE_11
    o_hold_busy_data_pin_oe = pins_active && (mode_is_parallel(mode) || mode_is_spi(mode));
    o_serial_out_select_out = mode_is_master_spi(mode) ? 1'b0 : link_last_bit; // RULE_14
    o_serial_out_select_oe = pins_active && (mode_is_master_spi(mode) || slave_active);
    o_mode_pullup_en = (state != ST_DONE); // RULE_08
    o_init_pullup_en = (state != ST_DONE);
    o_tms_pullup_en = (state != ST_DONE);
    o_tdi_pullup_en = (state != ST_DONE);
    o_restart_pullup_en = 1'b1; // RULE_09
    o_tck_pullup_en = 1'b0;
    o_mode = mode;
    o_mode_valid = mode_valid;
    o_pin_port_locked = (port_sel == PORT_PINS);
    o_tap_port_locked = (port_sel == PORT_TAP);
    o_configuring = (state != ST_DONE);
    o_shared_pins_gpio = (state == ST_DONE); // RULE_15
  end

endmodule : config_port_pin_control

// [verification/config_port_pin_control_asserts.sv]
// Concurrent checks on the ports of the configuration pin control.
// Assumes a bind to config_port_pin_control; everything is watched on the reference clock.
`timescale 1ns/10ps
module config_port_pin_control_asserts
  import config_port_pkg::*;
(
  input wire logic i_ref_clk,
  input wire logic i_rst_n,
  input wire logic i_config_restart_n,
  input wire logic i_tap_config_request,
  input wire logic i_load_complete,
  input wire logic o_init_ready_n_out,
  input wire logic o_init_ready_n_oe,
  input wire logic o_done_out,
  input wire logic o_done_oe,
  input wire logic o_config_clock_pin_oe,
  input wire logic o_mode_pullup_en,
  input wire logic o_init_pullup_en,
  input wire logic o_restart_pullup_en,
  input wire logic o_tck_pullup_en,
  input wire logic [2:0] o_mode,
  input wire logic o_mode_valid,
  input wire logic o_pin_port_locked,
  input wire logic o_tap_port_locked,
  input wire logic o_configuring,
  input wire logic o_shared_pins_gpio,
  input wire logic o_restart_accepted
);
  default clocking cb @(posedge i_ref_clk); endclocking
  default disable iff (!i_rst_n);
  logic [3:0] low_cnt;
  logic acc_seen;
  // The count saturates so that a long restart hold cannot wrap back to a short one.
  always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
    if (!i_rst_n) low_cnt <= 4'h0;
    else if (i_config_restart_n) low_cnt <= 4'h0;
    else if (low_cnt != 4'hF) low_cnt <= low_cnt + 4'h1;
  end
  always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
    if (!i_rst_n) acc_seen <= 1'b0;
    else if (i_config_restart_n) acc_seen <= 1'b0;
    else if (o_restart_accepted) acc_seen <= 1'b1;
  end
  chk_fixed_pullups: assert property (o_restart_pullup_en && !o_tck_pullup_en)
    else $error("restart or test clock pull-up wrong");
  chk_open_drain_low: assert property (!o_init_ready_n_out && !o_done_out)
    else $error("open-drain pin driven high");
  chk_done_gpio: assert property (o_done_oe == o_configuring && o_shared_pins_gpio != o_configuring)
    else $error("done or shared pins disagree with configuring");
  chk_config_pullups: assert property (o_configuring |-> o_mode_pullup_en && o_init_pullup_en)
    else $error("pull-up missing during configuration");
  chk_short_reject: assert property (o_restart_accepted |-> low_cnt >= 4'h6)
    else $error("restart accepted on a short pulse");
  chk_long_accept: assert property (low_cnt == 4'hC |-> acc_seen)
    else $error("long restart pulse not accepted");
  chk_restart_init: assert property (o_restart_accepted |-> ##[1:2] (o_init_ready_n_oe && !o_mode_valid))
    else $error("restart did not pull init-ready low");
  chk_init_hold: assert property ($fell(o_init_ready_n_oe) |-> $past(o_init_ready_n_oe, 5))
    else $error("init-ready released too early");
  chk_lock_stable: assert property ((o_pin_port_locked || o_tap_port_locked) |=> $stable({o_pin_port_locked, o_tap_port_locked}))
    else $error("port lock changed");
  chk_tap_claim: assert property (!o_pin_port_locked && !o_tap_port_locked && i_tap_config_request |-> ##[1:3] o_tap_port_locked)
    else $error("test port request not honoured");
  chk_clock_dir: assert property (o_config_clock_pin_oe |-> o_mode == MODE_MASTER_SPI || o_mode == MODE_MASTER_MULTI_BIT_SERIAL_FLASH_MODE || o_mode == MODE_MASTER_SERIAL)
    else $error("clock pin driven in a slave mode");
  chk_load_done: assert property (i_load_complete && o_mode_valid && o_configuring |-> ##[1:2] o_shared_pins_gpio)
    else $error("load complete did not end configuration");
endmodule : config_port_pin_control_asserts

// [verification/config_host_model.sv]
// Behavioural host and serial flash on the far side of the configuration pins.
// Assumes the testbench feeds the resolved wire levels from here into the block.
`timescale 1ns/10ps
module config_host_model (
  input wire logic i_rst_n,
  input wire logic i_master_clk,
  input wire logic i_master_cs,
  input wire logic i_master_cs_oe,
  input wire logic i_bit0_oe,
  input wire logic i_bit1_oe,
  input wire logic i_init_oe,
  output logic o_link_clk,
  output logic o_cs_n,
  output logic o_bit0,
  output logic o_bit1,
  output logic o_init_n
);
  localparam logic [7:0] FLASH_BYTE = 8'hC5;
  logic d0;
  logic d1;
  logic cs_wire;
  logic [31:0] cmd_rx;
  int nbits;
  // Released init-ready rises to its pull-up level; released data bits take the level the host or flash drives.
  assign o_init_n = i_init_oe ? 1'b0 : 1'b1;
  assign o_bit0 = i_bit0_oe ? 1'b0 : d0;
  assign o_bit1 = i_bit1_oe ? 1'b0 : d1;
  assign cs_wire = i_master_cs_oe ? i_master_cs : 1'b1;
  initial begin
    o_link_clk = 1'b0;
    o_cs_n = 1'b1;
    d0 = 1'b1;
  end
  always @(posedge i_master_clk or posedge cs_wire) begin
    if (cs_wire) nbits <= 0;
    else begin
      cmd_rx <= {cmd_rx[30:0], o_bit0};
      nbits <= nbits + 1;
    end
  end
  always @(negedge i_master_clk or posedge cs_wire) begin
    if (cs_wire) d1 <= 1'b1;
    else if (nbits >= 32) d1 <= FLASH_BYTE[7 - ((nbits - 32) % 8)];
  end
  task automatic set_cs(input logic v);
    o_cs_n = v;
  endtask : set_cs
  // Called only once init-ready has been released. 
  task automatic send_byte(input logic [7:0] b);
    o_cs_n = 1'b0;
    for (int i = 7; i >= 0; i--) begin
      d0 = b[i];
      #6 o_link_clk = 1'b1;
      #6 o_link_clk = 1'b0;
    end
    #6 o_cs_n = 1'b1;
    d0 = 1'b1;
  endtask : send_byte
endmodule : config_host_model

// [verification/testbench.sv]
// Self-checking bench for the configuration pin control with a host and flash model.
// Assumes the package constants and the host model; the engine is always ready.
`timescale 1ns/10ps
module testbench;
  import config_port_pkg::*;
  localparam logic [7:0] READ_CMD = 8'h03;
  logic i_ref_clk, i_rst_n, i_config_clock_pin_in, i_config_restart_n, i_init_ready_n_in;
  logic [2:0] i_mode_select, o_mode;
  logic i_config_data_bit0_in, i_config_data_bit1_in, i_primary_chip_select_n;
  logic i_second_chip_select_n, i_write_strobe_n, i_tap_config_request, i_engine_ready;
  logic i_engine_busy, i_load_complete, o_init_ready_n_out, o_init_ready_n_oe, o_done_out;
  logic o_done_oe, o_config_clock_pin_out, o_config_clock_pin_oe, o_config_data_bit0_out;
  logic o_config_data_bit0_oe, o_config_data_bit1_out, o_config_data_bit1_oe;
  logic o_hold_busy_data_pin_out, o_hold_busy_data_pin_oe, o_serial_out_select_out;
  logic o_serial_out_select_oe, o_mode_pullup_en, o_init_pullup_en, o_tms_pullup_en;
  logic o_tdi_pullup_en, o_restart_pullup_en, o_tck_pullup_en, o_mode_valid;
  logic o_pin_port_locked, o_tap_port_locked, o_configuring, o_shared_pins_gpio;
  logic o_restart_accepted, o_config_byte_valid, o_parallel_write, mclk;
  logic [7:0] o_config_byte;
  int errors = 0;
  int cmp_count = 0;
  int cycles = 0;
  assign mclk = o_config_clock_pin_oe & o_config_clock_pin_out;
  config_port_pin_control #(.MASTER_HALF_CYCLES(4), .FLASH_READ_CMD(READ_CMD)) u_dut (.*);
  config_host_model u_host (.i_rst_n, .i_master_clk(mclk), .i_master_cs(o_serial_out_select_out),
    .i_master_cs_oe(o_serial_out_select_oe), .i_bit0_oe(o_config_data_bit0_oe),
    .i_bit1_oe(o_config_data_bit1_oe), .i_init_oe(o_init_ready_n_oe),
    .o_link_clk(i_config_clock_pin_in), .o_cs_n(i_primary_chip_select_n),
    .o_bit0(i_config_data_bit0_in), .o_bit1(i_config_data_bit1_in), .o_init_n(i_init_ready_n_in));
  initial begin
    i_ref_clk = 1'b0;
    forever #5 i_ref_clk = ~i_ref_clk;
  end
  always @(posedge i_ref_clk) begin
    cycles++;
    if (cycles == 6000) begin
      errors++;
      $display("[ERR] run_length expected finish seen timeout");
      end_of_test();
    end
  end
  task automatic end_of_test();
    $display("Comparisons %0d mismatches %0d", cmp_count, errors);
    if (errors == 0 && cmp_count > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask : end_of_test
  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      errors++;
      $display("[ERR] %s expected %0h seen %0h", name, exp, seen);
    end
  endtask : check
  // Inputs move 1 ns after the edge so the block never samples them mid-change.
  task automatic step(input int n);
    repeat (n) @(posedge i_ref_clk);
    #1;
  endtask : step
  task automatic wait_mode(input logic [2:0] m);
    int n;
    n = 0;
    while (o_mode_valid !== 1'b1 && n < 60) begin
      step(1);
      n++;
    end
    check("mode", o_mode, m);
    check("pin_lock", o_pin_port_locked, 1'b1);
  endtask : wait_mode
  task automatic enter_mode(input logic [2:0] m);
    i_mode_select = m;
    i_config_restart_n = 1'b0;
    step(12);
    i_config_restart_n = 1'b1;
    wait_mode(m);
  endtask : enter_mode
  task automatic wait_byte(input logic [7:0] exp, input int lim);
    int n;
    n = 0;
    while (o_config_byte_valid !== 1'b1 && n < lim) begin
      step(1);
      n++;
    end
    check("byte_valid", o_config_byte_valid, 1'b1);
    check("config_byte", o_config_byte, exp);
  endtask : wait_byte
  task automatic t_slave_serial();
    check("done_oe", o_done_oe, 1'b1);
    check("gpio", o_shared_pins_gpio, 1'b0);
    fork
      u_host.send_byte(8'hA5);
      wait_byte(8'hA5, 30);
    join
    check("clk_oe", o_config_clock_pin_oe, 1'b0);
    i_mode_select = MODE_SLAVE_PARALLEL;
    step(4);
    check("mode_kept", o_mode, MODE_SLAVE_SERIAL);
    i_config_restart_n = 1'b0;
    step(5);
    i_config_restart_n = 1'b1;
    step(15);
    check("short_restart", o_mode_valid, 1'b1);
    $display("test slave_serial ended");
  endtask : t_slave_serial
  task automatic t_spi();
    enter_mode(MODE_SLAVE_SPI);
    fork
      u_host.send_byte(8'h3C);
      wait_byte(8'h3C, 30);
    join
    check("hold_oe", o_hold_busy_data_pin_oe, 1'b1);
    check("hold_out", o_hold_busy_data_pin_out, 1'b1);
    check("bit1_echo", o_config_data_bit1_oe, 1'b1);
    enter_mode(MODE_MASTER_SPI);
    step(4);
    check("clk_oe", o_config_clock_pin_oe, 1'b1);
    check("flash_sel", o_serial_out_select_out, 1'b0);
    for (int n = 0; n < 400 && u_host.nbits < 32; n++) step(1);
    check("read_cmd", u_host.cmd_rx, {READ_CMD, 24'h000000});
    wait_byte(8'hC5, 200);
    enter_mode(MODE_MASTER_MULTI_BIT_SERIAL_FLASH_MODE);
    step(4);
    check("multi_bit_serial_flash_mode_clk_oe", o_config_clock_pin_oe, 1'b1);
    enter_mode(MODE_MASTER_SERIAL);
    step(4);
    check("ms_clk_oe", o_config_clock_pin_oe, 1'b1);
    $display("test spi ended");
  endtask : t_spi
  task automatic t_parallel();
    int n;
    enter_mode(MODE_SLAVE_PARALLEL);
    i_engine_busy = 1'b1;
    u_host.set_cs(1'b0);
    i_second_chip_select_n = 1'b0;
    step(3);
    check("busy_oe", o_hold_busy_data_pin_oe, 1'b1);
    check("busy_out", o_hold_busy_data_pin_out, 1'b1);
    i_write_strobe_n = 1'b0;
    n = 0;
    while (o_parallel_write !== 1'b1 && n < 6) begin
      step(1);
      n++;
    end
    check("write", o_parallel_write, 1'b1);
    i_write_strobe_n = 1'b1;
    i_engine_busy = 1'b0;
    step(3);
    check("idle_out", o_hold_busy_data_pin_out, 1'b0);
    u_host.set_cs(1'b1);
    i_second_chip_select_n = 1'b1;
    i_load_complete = 1'b1;
    step(1);
    i_load_complete = 1'b0;
    step(3);
    check("gpio", o_shared_pins_gpio, 1'b1);
    check("done_oe", o_done_oe, 1'b0);
    check("pullup", {o_mode_pullup_en, o_init_pullup_en, o_tms_pullup_en, o_tdi_pullup_en}, 4'h0);
    $display("test parallel ended");
  endtask : t_parallel
  task automatic t_tap();
    enter_mode(MODE_SLAVE_SERIAL);
    i_tap_config_request = 1'b1;
    step(1);
    i_tap_config_request = 1'b0;
    step(3);
    check("tap_refused", o_tap_port_locked, 1'b0);
    i_rst_n = 1'b0;
    step(3);
    i_rst_n = 1'b1;
    i_tap_config_request = 1'b1;
    step(1);
    i_tap_config_request = 1'b0;
    step(30);
    check("tap_lock", o_tap_port_locked, 1'b1);
    check("pin_lock", o_pin_port_locked, 1'b0);
    $display("test tap ended");
  endtask : t_tap
  initial begin
    i_rst_n = 1'b0;
    i_config_restart_n = 1'b1;
    i_mode_select = MODE_SLAVE_SERIAL;
    i_second_chip_select_n = 1'b1;
    i_write_strobe_n = 1'b1;
    i_tap_config_request = 1'b0;
    i_engine_ready = 1'b1;
    i_engine_busy = 1'b0;
    i_load_complete = 1'b0;
    step(10);
    i_rst_n = 1'b1;
    wait_mode(MODE_SLAVE_SERIAL);
    t_slave_serial();
    t_spi();
    t_parallel();
    t_tap();
    end_of_test();
  end
endmodule : testbench
bind config_port_pin_control config_port_pin_control_asserts u_chk (.*);
